/* File: pkg/dml_regs.svh */
// field positions, masks and reset values of the debug match registers
`ifndef DML_REGS_SVH
`define DML_REGS_SVH

`define DML_MEANING_BIT 21
`define DML_LINK_BIT 20
`define DML_LINKED_HI 19
`define DML_LINKED_LO 16
`define DML_LANE_HI 8
`define DML_LANE_LO 5
`define DML_PRIV_HI 2
`define DML_PRIV_LO 1
`define DML_ENABLE_BIT 0
`define DML_CTX_PAIR_A 4'h4
`define DML_CTX_PAIR_B 4'h5
`define DML_BCTRL_WMASK 32'h003F01E7
`define DML_WCTRL_WMASK 32'h001F01FF
`define DML_WVAL_WMASK 32'hFFFFFFFC
`define DML_REG_RESET 32'h00000000
`define DML_PRIV_ONLY 2'h1
`define DML_USER_ONLY 2'h2
`define DML_PRIV_ANY 2'h3
`define DML_ALL_LANES 4'hF

`endif

/* File: pkg/dml_pkg.sv */
// types shared by the debug match linking logic
`default_nettype none
package dml_pkg;
	typedef enum logic [1:0]
	{
		DML_SEL_BVAL,
		DML_SEL_BCTRL,
		DML_SEL_WVAL,
		DML_SEL_WCTRL
	} dml_regkind_t;
endpackage : dml_pkg
`default_nettype wire

/* File: rtl/dml_match.sv */
// one value comparator with byte lane and privilege qualification
`default_nettype none
`include "dml_regs.svh"
module dml_match
(
	input wire logic [31:0] value,
	input wire logic [31:0] target,
	input wire logic [3:0] laneSel,
	input wire logic [3:0] accessLanes,
	input wire logic isContext,
	input wire logic [1:0] privField,
	input wire logic accessPriv,
	output logic valueHit,
	output logic privOk
);
	logic [3:0] laneEq;
	logic ctxHit;
	logic addrHit;

	// context compare checks each selected byte
	genvar g;
	generate
		for (g = 0; g < 4; g++)
		begin : gLane
			assign laneEq[g] = !laneSel[g] || (value[8*g +: 8] == target[8*g +: 8]);
		end
	endgenerate

	always_comb
	begin
		ctxHit = (|laneSel) && (&laneEq);
		addrHit = (value[31:2] == target[31:2]) && (|(laneSel & accessLanes));
		valueHit = isContext ? ctxHit : addrHit;
		unique case (privField)
			`DML_PRIV_ONLY: privOk = accessPriv;
			`DML_USER_ONLY: privOk = !accessPriv;
			`DML_PRIV_ANY: privOk = 1'b1;
			default: privOk = 1'b0;
		endcase
	end
endmodule : dml_match
`default_nettype wire

/* File: rtl/debug_match_linking.sv */
// breakpoint and watchpoint pairs with context identifier linking
`default_nettype none
`include "dml_regs.svh"
// Operation
// - meaning bit selects fetch address (0) or context identifier (1) as compare target
// - link bit marks a breakpoint pair as taking part in linking
// - mode 00: fetch address match alone raises a breakpoint event
// - mode 01: address match plus named context pair match on same fetch
// - mode 10: context identifier match alone raises a breakpoint event
// - mode 11: pair only serves as context target for linked pairs
// - any number of pairs may link to one context pair at once
// - only pairs four and five hold context identifiers; others are never link targets
// - linked events use the privilege qualifier of the address pair
// - byte lane select also gates context comparisons; software sets all lanes
// - context-only event dropped in privileged mode under monitor debug mode
// - privilege qualifier applies to unlinked (mode 10) context comparisons too
// - qualifier 01 privileged, 10 user, 11 any, 00 never
// - linked address pair raises nothing unless both pairs are enabled
// - each lane bit matches one little-endian byte; zero lanes never match
module debug_match_linking
#(
	parameter int NB = 6,
	parameter int NW = 2
)
(
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic regWrEn,
	input wire logic regRdEn,
	input wire dml_pkg::dml_regkind_t regKind,
	input wire logic [3:0] regIndex,
	input wire logic [31:0] regWrData,
	output logic [31:0] regRdData,
	input wire logic fetchValid,
	input wire logic [31:0] fetchAddr,
	input wire logic [3:0] fetchByteEn,
	input wire logic fetchPriv,
	input wire logic dataValid,
	input wire logic [31:0] dataAddr,
	input wire logic [3:0] dataByteEn,
	input wire logic dataPriv,
	input wire logic [31:0] contextId,
	input wire logic monitorMode,
	output logic breakpointEvent,
	output logic watchpointEvent,
	output logic [NB-1:0] breakpointHits,
	output logic [NW-1:0] watchpointHits
);
	typedef struct packed
	{
		logic [NB-1:0][31:0] bval;
		logic [NB-1:0][31:0] bctrl;
		logic [NW-1:0][31:0] wval;
		logic [NW-1:0][31:0] wctrl;
		logic [31:0] rdData;
		logic bpEvent;
		logic wpEvent;
		logic [NB-1:0] bpHits;
		logic [NW-1:0] wpHits;
	} dml_state_t;

	dml_state_t st_reg;
	dml_state_t st_next;
	logic [NB-1:0] bValueHit;
	logic [NB-1:0] bPrivOk;
	logic [NB-1:0] bHit;
	logic [NB-1:0] ctxTarget;
	logic [15:0] ctxTargetWide;
	logic [NW-1:0] wValueHit;
	logic [NW-1:0] wPrivOk;
	logic [NW-1:0] wHit;

	assign ctxTargetWide = 16'(ctxTarget);

	// linked pair must be four or five and be a ready context target
	function automatic logic linkOk(input logic [3:0] idx, input logic [15:0] tgt);
		linkOk = ((idx == `DML_CTX_PAIR_A) || (idx == `DML_CTX_PAIR_B)) && tgt[idx];
	endfunction : linkOk

	genvar i;
	generate
		for (i = 0; i < NB; i++)
		begin : gBrk
			logic ctxCapable;
			logic meaning;
			logic link;
			logic en;
			logic [3:0] linked;
			assign ctxCapable = (i == 4) || (i == 5);
			assign meaning = ctxCapable && st_reg.bctrl[i][`DML_MEANING_BIT];
			assign link = st_reg.bctrl[i][`DML_LINK_BIT];
			assign en = st_reg.bctrl[i][`DML_ENABLE_BIT];
			assign linked = st_reg.bctrl[i][`DML_LINKED_HI:`DML_LINKED_LO];
			dml_match uMatch
			(
				.value(st_reg.bval[i]),
				.target(meaning ? contextId : fetchAddr),
				.laneSel(st_reg.bctrl[i][`DML_LANE_HI:`DML_LANE_LO]),
				.accessLanes(meaning ? `DML_ALL_LANES : fetchByteEn),
				.isContext(meaning),
				.privField(st_reg.bctrl[i][`DML_PRIV_HI:`DML_PRIV_LO]),
				.accessPriv(fetchPriv),
				.valueHit(bValueHit[i]),
				.privOk(bPrivOk[i])
			);
			// context target ignores its own qualifier when linked
			assign ctxTarget[i] = en && meaning && link && bValueHit[i];
			always_comb
			begin
				unique case ({meaning, link})
					2'h0: bHit[i] = en && bValueHit[i] && bPrivOk[i];
					2'h1: bHit[i] = en && bValueHit[i] && bPrivOk[i]
						&& linkOk(linked, ctxTargetWide);
					2'h2: bHit[i] = en && bValueHit[i] && bPrivOk[i]
						&& !(fetchPriv && monitorMode);
					2'h3: bHit[i] = 1'b0;
				endcase
			end
		end
		for (i = 0; i < NW; i++)
		begin : gWat
			logic link;
			logic en;
			assign link = st_reg.wctrl[i][`DML_LINK_BIT];
			assign en = st_reg.wctrl[i][`DML_ENABLE_BIT];
			dml_match uMatch
			(
				.value(st_reg.wval[i]),
				.target(dataAddr),
				.laneSel(st_reg.wctrl[i][`DML_LANE_HI:`DML_LANE_LO]),
				.accessLanes(dataByteEn),
				.isContext(1'b0),
				.privField(st_reg.wctrl[i][`DML_PRIV_HI:`DML_PRIV_LO]),
				.accessPriv(dataPriv),
				.valueHit(wValueHit[i]),
				.privOk(wPrivOk[i])
			);
			assign wHit[i] = en && wValueHit[i] && wPrivOk[i] && (!link
				|| linkOk(st_reg.wctrl[i][`DML_LINKED_HI:`DML_LINKED_LO],
				ctxTargetWide));
		end
	endgenerate

	always_comb
	begin
		st_next = st_reg;
		if (regWrEn)
		begin
			unique case (regKind)
				dml_pkg::DML_SEL_BVAL:
					if (regIndex < 4'(NB))
						st_next.bval[regIndex] = regWrData;
				dml_pkg::DML_SEL_BCTRL:
					if (regIndex < 4'(NB))
						st_next.bctrl[regIndex] = regWrData & `DML_BCTRL_WMASK;
				dml_pkg::DML_SEL_WVAL:
					if (regIndex < 4'(NW))
						st_next.wval[regIndex] = regWrData & `DML_WVAL_WMASK;
				dml_pkg::DML_SEL_WCTRL:
					if (regIndex < 4'(NW))
						st_next.wctrl[regIndex] = regWrData & `DML_WCTRL_WMASK;
			endcase
		end
		if (regRdEn)
		begin
			st_next.rdData = `DML_REG_RESET;
			unique case (regKind)
				dml_pkg::DML_SEL_BVAL:
					if (regIndex < 4'(NB))
						st_next.rdData = st_reg.bval[regIndex];
				dml_pkg::DML_SEL_BCTRL:
					if (regIndex < 4'(NB))
						st_next.rdData = st_reg.bctrl[regIndex];
				dml_pkg::DML_SEL_WVAL:
					if (regIndex < 4'(NW))
						st_next.rdData = st_reg.wval[regIndex];
				dml_pkg::DML_SEL_WCTRL:
					if (regIndex < 4'(NW))
						st_next.rdData = st_reg.wctrl[regIndex];
			endcase
		end
		st_next.bpHits = fetchValid ? bHit : '0;
		st_next.wpHits = dataValid ? wHit : '0;
		st_next.bpEvent = fetchValid && (|bHit);
		st_next.wpEvent = dataValid && (|wHit);
	end

	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
			st_reg <= '0;
		else
			st_reg <= st_next;
	end

	assign regRdData = st_reg.rdData;
	assign breakpointEvent = st_reg.bpEvent;
	assign watchpointEvent = st_reg.wpEvent;
	assign breakpointHits = st_reg.bpHits;
	assign watchpointHits = st_reg.wpHits;
endmodule : debug_match_linking
`default_nettype wire

/* File: sim/dml_sva.sv */
// checker on the debug match linking ports
`default_nettype none
`include "dml_regs.svh"
module dml_sva
#(
	parameter int NB = 6,
	parameter int NW = 2
)
(
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic regWrEn,
	input wire logic regRdEn,
	input wire dml_pkg::dml_regkind_t regKind,
	input wire logic [3:0] regIndex,
	input wire logic [31:0] regWrData,
	input wire logic [31:0] regRdData,
	input wire logic fetchValid,
	input wire logic dataValid,
	input wire logic [3:0] dataByteEn,
	input wire logic breakpointEvent,
	input wire logic watchpointEvent,
	input wire logic [NB-1:0] breakpointHits,
	input wire logic [NW-1:0] watchpointHits
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_n);
	AST_BPULSE: assert property (!fetchValid |=> !breakpointEvent)
		else $error("stray breakpoint event");
	AST_WPULSE: assert property (!dataValid |=> !watchpointEvent)
		else $error("stray watchpoint event");
	AST_BSUM: assert property (breakpointEvent == (|breakpointHits))
		else $error("breakpoint event and hits differ");
	AST_WSUM: assert property (watchpointEvent == (|watchpointHits))
		else $error("watchpoint event and hits differ");
	AST_NOLANE: assert property (dataValid && dataByteEn == 4'h0 |=> !watchpointEvent)
		else $error("event without byte lanes");
	AST_RDHOLD: assert property (!regRdEn |=> $stable(regRdData))
		else $error("read data moved");
	AST_WIDX: assert property (regRdEn && regKind == dml_pkg::DML_SEL_WCTRL && regIndex >= NW
		|=> regRdData == 32'h0)
		else $error("unmapped read not zero");
	AST_BBACK: assert property (regWrEn && regKind == dml_pkg::DML_SEL_BCTRL && regIndex < NB
		##1 regRdEn && !regWrEn && $stable(regKind) && $stable(regIndex)
		|=> regRdData == ($past(regWrData, 2) & `DML_BCTRL_WMASK))
		else $error("control read back wrong");
endmodule : dml_sva
`default_nettype wire

/* File: sim/dml_core_model.sv */
// behavioural core: fetch, data and context buses
`default_nettype none
module dml_core_model
(
	input wire logic mclk,
	output logic fetchValid,
	output logic [31:0] fetchAddr,
	output logic [3:0] fetchByteEn,
	output logic fetchPriv,
	output logic dataValid,
	output logic [31:0] dataAddr,
	output logic [3:0] dataByteEn,
	output logic dataPriv,
	output logic [31:0] contextId
);
	timeunit 1ns;
	timeprecision 1ns;
	initial
	begin
		{fetchValid, fetchAddr, fetchByteEn, fetchPriv} = '0;
		{dataValid, dataAddr, dataByteEn, dataPriv, contextId} = '0;
	end
	// one idle cycle, one access for one cycle, then idle buses show inverted addresses
	task automatic acc(input logic [31:0] a, input logic [3:0] b, input logic p, input logic d,
		input logic [31:0] c);
		@(posedge mclk);
		#1;
		contextId = c;
		fetchValid = !d;
		dataValid = d;
		{fetchAddr, fetchByteEn, fetchPriv} = {a, b, p};
		{dataAddr, dataByteEn, dataPriv} = {a, b, p};
		@(posedge mclk);
		#1;
		{fetchValid, dataValid} = 2'h0;
		{fetchAddr, dataAddr} = {~a, ~a};
	endtask : acc
endmodule : dml_core_model
`default_nettype wire

/* File: sim/debug_match_linking_tb.sv */
// self-checking bench for the debug match linking block
`default_nettype none
module debug_match_linking_tb;
	timeunit 1ns;
	timeprecision 1ns;
	localparam dml_pkg::dml_regkind_t BV = dml_pkg::DML_SEL_BVAL;
	localparam dml_pkg::dml_regkind_t BC = dml_pkg::DML_SEL_BCTRL;
	localparam dml_pkg::dml_regkind_t WV = dml_pkg::DML_SEL_WVAL;
	localparam dml_pkg::dml_regkind_t WC = dml_pkg::DML_SEL_WCTRL;
	localparam logic [31:0] CTX = 32'h1234ABCD;
	localparam logic [31:0] IA = 32'h00008000;
	logic mclk = 1'b0;
	logic rst_n = 1'b0;
	logic regWrEn = 1'b0;
	logic regRdEn = 1'b0;
	logic monitorMode = 1'b0;
	dml_pkg::dml_regkind_t regKind = BV;
	logic [3:0] regIndex = 4'h0;
	logic [31:0] regWrData = 32'h0;
	logic [31:0] regRdData, fetchAddr, dataAddr, contextId;
	logic [3:0] fetchByteEn, dataByteEn;
	logic fetchValid, fetchPriv, dataValid, dataPriv, breakpointEvent, watchpointEvent;
	logic [5:0] breakpointHits;
	logic [1:0] watchpointHits;
	int nErrors = 0;
	int checked = 0;
	always #50 mclk = ~mclk;
	debug_match_linking dut
	(
		.mclk, .rst_n, .regWrEn, .regRdEn, .regKind, .regIndex, .regWrData, .regRdData,
		.fetchValid, .fetchAddr, .fetchByteEn, .fetchPriv, .dataValid, .dataAddr, .dataByteEn,
		.dataPriv, .contextId, .monitorMode, .breakpointEvent, .watchpointEvent,
		.breakpointHits, .watchpointHits
	);
	dml_core_model core
	(
		.mclk, .fetchValid, .fetchAddr, .fetchByteEn, .fetchPriv, .dataValid, .dataAddr,
		.dataByteEn, .dataPriv, .contextId
	);
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp)
		begin
			nErrors++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic wr(input dml_pkg::dml_regkind_t k, input logic [3:0] i, input logic [31:0] v);
		// strobe stays up until another call, so no signal is set twice at one instant
		regRdEn = 1'b0;
		regWrEn = 1'b1;
		regKind = k;
		regIndex = i;
		regWrData = v;
		@(posedge mclk);
		#1;
	endtask : wr
	task automatic rd(input dml_pkg::dml_regkind_t k, input logic [3:0] i, input logic [31:0] e);
		regWrEn = 1'b0;
		regRdEn = 1'b1;
		regKind = k;
		regIndex = i;
		@(posedge mclk);
		#1;
		chk(regRdData, e);
	endtask : rd
	// expectation is {breakpoint hits, watchpoint hits}
	task automatic go(input logic [31:0] a, input logic p, input logic d, input logic [31:0] c,
		input logic [7:0] e);
		core.acc(a, 4'hF, p, d, c);
		chk({22'h0, breakpointEvent, watchpointEvent, breakpointHits, watchpointHits},
			{22'h0, |e[7:2], |e[1:0], e});
	endtask : go
	task automatic final_report;
		$display("errors %0d checks %0d", nErrors, checked);
		if (nErrors == 0 && checked > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : final_report
	initial
	begin
		repeat (3) @(posedge mclk);
		#1;
		rst_n = 1'b1;
		rd(BC, 4'h0, 32'h0);
		rd(WC, 4'h6, 32'h0);
		wr(BV, 4'h4, CTX);
		wr(BC, 4'h4, 32'h003001E7);
		rd(BV, 4'h4, CTX);
		wr(BV, 4'h0, IA);
		wr(BC, 4'h0, 32'h001401E7);
		rd(BC, 4'h0, 32'h001401E7);
		wr(WV, 4'h0, IA | 32'h00000003);
		rd(WV, 4'h0, IA);
		wr(WC, 4'h0, 32'h001401E7);
		go(IA, 1'b0, 1'b0, CTX, 8'h04);
		go(IA, 1'b0, 1'b0, ~CTX, 8'h00);
		go(IA, 1'b0, 1'b1, CTX, 8'h01);
		core.acc(IA, 4'h0, 1'b0, 1'b1, CTX);
		chk({31'h0, watchpointEvent}, 32'h0);
		wr(BC, 4'h0, 32'h001301E7);
		go(IA, 1'b0, 1'b0, CTX, 8'h00);
		wr(BC, 4'h4, 32'h003001E6);
		go(IA, 1'b0, 1'b1, CTX, 8'h00);
		wr(WC, 4'h0, 32'h000001E7);
		go(IA, 1'b0, 1'b1, ~CTX, 8'h01);
		wr(BV, 4'h5, CTX);
		wr(BC, 4'h5, 32'h002001E7);
		go(32'h00000100, 1'b0, 1'b0, CTX, 8'h80);
		monitorMode = 1'b1;
		go(32'h00000100, 1'b1, 1'b0, CTX, 8'h00);
		go(32'h00000100, 1'b0, 1'b0, CTX, 8'h80);
		monitorMode = 1'b0;
		wr(BC, 4'h5, 32'h002001E3);
		go(32'h00000100, 1'b0, 1'b0, CTX, 8'h00);
		go(32'h00000100, 1'b1, 1'b0, CTX, 8'h80);
		for (int q = 0; q < 4; q++)
		begin
			wr(BC, 4'h0, 32'h000001E1 | {29'h0, q[1:0], 1'b0});
			go(IA, 1'b0, 1'b0, ~CTX, {5'h0, q[1], 2'h0});
			go(IA, 1'b1, 1'b0, ~CTX, {5'h0, q[0], 2'h0});
		end
		final_report();
	end
endmodule : debug_match_linking_tb
bind debug_match_linking dml_sva #(.NB(NB), .NW(NW)) u_sva
(
	.mclk, .rst_n, .regWrEn, .regRdEn, .regKind, .regIndex, .regWrData, .regRdData,
	.fetchValid, .dataValid, .dataByteEn, .breakpointEvent, .watchpointEvent,
	.breakpointHits, .watchpointHits
);
`default_nettype wire
